/* File: hbpc_pkg.sv */
// Purpose: shared constants for the host bus pin configuration block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: control and status layouts used by the top and the bench
package hbpc_pkg;
   // register bus
   localparam int AXI_AW = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   ////////////////////////////////////////////////////////////////////////
   // control register fields
   localparam int CTRL_IRQ_POL = 0;
   localparam int CTRL_IRQ_OD = 1;
   localparam int CTRL_SLEEP = 2;
   localparam int CTRL_DMODE_LSB = 4;
   localparam int CTRL_CMODE_LSB = 6;
   localparam int CTRL_GENERAL_OUTPUT_THREE = 8;
   localparam int CTRL_GENERAL_OUTPUT_FOUR = 9;
   localparam int CTRL_IEN_LSB = 12;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_f3f3;
   ////////////////////////////////////////////////////////////////////////
   // status register fields
   localparam int ST_W32 = 0;
   localparam int ST_RATE = 1;
   localparam int ST_SLEEP = 2;
   localparam int ST_RDSEEN = 3;
   localparam int ST_IRQ_LSB = 4;
   ////////////////////////////////////////////////////////////////////////
   // host side decode and sizes
   localparam int IRQ_SRC_N = 4;
   localparam int CSR_AW = 6;
   localparam logic [2:0] FIFO_REGION = 3'h0;
   localparam int REF_CLK_HZ = 50_000_000;
   localparam int XTAL_HZ = 25_000_000;
   // function of a shared serial rom pin
   typedef enum logic [1:0] {
      PM_ROM,
      PM_GPO,
      PM_MON_A,
      PM_MON_B
   } hbpc_pinmode_t;
endpackage

/* File: hbpc_csr_mem.sv */
// Purpose: word store behind the host control/status window
// Assumes: one write and one read port, same clock
// Notes: read data come out of a register one cycle after re
`timescale 1ns/10ps
module hbpc_csr_mem #(
   parameter int DW = 32,
   parameter int AW = 6
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // read port
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   ////////////////////////////////////////////////////////////////////////
   // storage
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered read
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule

/* File: hbpc_top.sv */
// Purpose: host bus pin port with straps and shared serial rom pins
// Assumes: host pins synchronous to ref_clk; 50 MHz clock
// Notes: control and status reached over AXI4-Lite
//
// Contract
// - split data port; upper pulldowns off in 32-bit
// - word address selects registers or fifos
// - strobes act only with chip select low
// - write strobe with chip select wakes device
// - irq polarity, sources, push-pull or open-drain
// - fifo select forces fifo, ignores upper address
// - rate strap picks default speed and autoneg
// - rate strap latched once at reset release
// - width strap latched: high 32-bit, low 16-bit
// - 16-bit mode pairs halves into 32-bit words
// - data rom pin: rom, output three, tx monitor
// - clock rom pin: rom, output four, rx monitor
// - rom select off unless data pin is rom
// - rom select off unless clock pin is rom
// - general outputs are output only
// - hw_reset_n low resets all logic except the csr store and its read register
// - reference clock from crystal input
`timescale 1ns/10ps
module hbpc_top
   import hbpc_pkg::*;
#(
   parameter int CSR_DEPTH_AW = CSR_AW
) (
   // clock and resets
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hw_reset_n,
   // axi4-lite write
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // host bus pins
   input wire logic [31:0] host_data_i,
   output logic [31:0] host_data_o,
   output logic host_data_oe_hi,
   output logic host_data_oe_lo,
   output logic data_hi_pulldown_en,
   input wire logic [7:1] host_addr,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chip_select_n,
   input wire logic fifo_window_select,
   // interrupt pin
   input wire logic [IRQ_SRC_N-1:0] irq_sources,
   output logic irq_o,
   output logic irq_oe,
   // straps and defaults
   input wire logic link_rate_strap,
   output logic bus_is_32,
   output logic dflt_speed_100,
   output logic dflt_full_duplex,
   output logic dflt_autoneg_en,
   // data fifos
   output logic tx_fifo_valid,
   output logic [31:0] tx_fifo_data,
   output logic rx_fifo_pop,
   input wire logic [31:0] rx_fifo_data,
   // serial rom pins
   input wire logic serial_rom_data_i,
   output logic serial_rom_data_o,
   output logic serial_rom_data_oe,
   output logic serial_rom_clock,
   output logic serial_rom_select,
   // serial rom engine
   input wire logic rom_eng_do,
   input wire logic rom_eng_oe,
   input wire logic rom_eng_clk,
   input wire logic rom_eng_cs,
   output logic rom_eng_di,
   // internal mii monitors
   input wire logic mii_tx_en,
   input wire logic mii_tx_clk,
   input wire logic mii_rx_dv,
   input wire logic mii_rx_clk,
   // power state
   output logic sleeping,
   output logic host_ready
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic aw_seen;
      logic [AXI_AW-1:0] aw_addr;
      logic w_seen;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic strap_done;
      logic w32;
      logic rate100;
      logic sleeping;
      logic read_seen;
      logic rd_act;
      logic wr_act;
      logic rd_pend;
      logic [31:0] rd_data;
      logic [15:0] rd_upper;
      logic [15:0] wr_low;
      logic tx_valid;
      logic [31:0] tx_data;
      logic sr_do;
      logic sr_oe;
      logic sr_clk;
      logic sr_cs;
      logic irq_o;
      logic irq_oe;
   } hbpc_state_t;

   localparam hbpc_state_t ST_RST = '{ctrl: CTRL_RST, default: '0};

   hbpc_state_t s_r;
   hbpc_state_t s_nxt;
   logic acc_rd;
   logic acc_wr;
   logic rd_start;
   logic wr_start;
   logic half_hi;
   logic fifo_hit;
   logic mem_we;
   logic mem_re;
   logic [CSR_DEPTH_AW-1:0] mem_addr;
   logic [31:0] mem_wdata;
   logic [31:0] mem_rdata;
   logic [31:0] wr_word;
   logic [31:0] status;
   logic irq_act;
   hbpc_pinmode_t dmode;
   hbpc_pinmode_t cmode;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic is_fifo(input logic [7:1] a, input logic fs);
      is_fifo = fs | (a[7:5] == FIFO_REGION);
   endfunction

   // returns {word seen by host, upper half kept for second read}
   function automatic logic [47:0] steer(input logic [31:0] w,
                                         input logic wide);
      steer = wide ? {w, 16'h0000} : {16'h0000, w[15:0], w[31:16]};
   endfunction

   function automatic logic reg_hit(input logic [AXI_AW-1:0] a,
                                    input logic [7:0] ofs);
      reg_hit = (a[AXI_AW-1:2] == ofs[7:2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // host strobe qualification and decode
   assign acc_rd = !chip_select_n && !read_strobe_n;
   assign acc_wr = !chip_select_n && !write_strobe_n;
   assign rd_start = acc_rd && !s_r.rd_act;
   assign wr_start = acc_wr && !s_r.wr_act;
   assign half_hi = host_addr[1];
   assign fifo_hit = is_fifo(host_addr, fifo_window_select);
   assign mem_addr = host_addr[7:2];
   assign wr_word = s_r.w32 ? host_data_i
                            : {host_data_i[15:0], s_r.wr_low};
   assign dmode = hbpc_pinmode_t'(s_r.ctrl[CTRL_DMODE_LSB +: 2]);
   assign cmode = hbpc_pinmode_t'(s_r.ctrl[CTRL_CMODE_LSB +: 2]);
   assign irq_act = |(irq_sources & s_r.ctrl[CTRL_IEN_LSB +: IRQ_SRC_N]);
   assign status = {24'h000000, irq_sources, s_r.read_seen, s_r.sleeping,
                    s_r.rate100, s_r.w32};

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt = s_r;
      mem_we = 1'b0;
      mem_re = 1'b0;
      mem_wdata = wr_word;
      rx_fifo_pop = 1'b0;
      s_nxt.tx_valid = 1'b0;
      s_nxt.rd_pend = 1'b0;
      s_nxt.rd_act = acc_rd;
      s_nxt.wr_act = acc_wr;
      // straps caught on first edge after release
      if (!s_r.strap_done) begin
         s_nxt.strap_done = 1'b1;
         s_nxt.w32 = serial_rom_data_i;
         s_nxt.rate100 = link_rate_strap;
      end
      // host read
      if (rd_start) begin
         s_nxt.read_seen = 1'b1;
         if (!s_r.w32 && half_hi) begin
            s_nxt.rd_data = {16'h0000, s_r.rd_upper};
         end else if (fifo_hit) begin
            rx_fifo_pop = 1'b1;
            {s_nxt.rd_data, s_nxt.rd_upper} = steer(rx_fifo_data, s_r.w32);
         end else begin
            mem_re = 1'b1;
            s_nxt.rd_pend = 1'b1;
         end
      end
      if (s_r.rd_pend) begin
         {s_nxt.rd_data, s_nxt.rd_upper} = steer(mem_rdata, s_r.w32);
      end
      // host write
      if (wr_start) begin
         if (s_r.sleeping) begin
            s_nxt.sleeping = 1'b0;
         end else if (s_r.read_seen) begin
            if (!s_r.w32 && !half_hi) begin
               s_nxt.wr_low = host_data_i[15:0];
            end else if (fifo_hit) begin
               s_nxt.tx_valid = 1'b1;
               s_nxt.tx_data = wr_word;
            end else begin
               mem_we = 1'b1;
            end
         end
      end
      // axi write address and data, either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_nxt.aw_seen = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_nxt.w_seen = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (s_r.aw_seen && s_r.w_seen) begin
         s_nxt.aw_seen = 1'b0;
         s_nxt.w_seen = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         if (reg_hit(s_r.aw_addr, OFS_CTRL)) begin
            for (int i = 0; i < 4; i++) begin
               if (s_r.w_strb[i]) begin
                  s_nxt.ctrl[i*8 +: 8] = s_r.w_data[i*8 +: 8]
                                          & CTRL_WMASK[i*8 +: 8];
               end
            end
            if (s_r.w_strb[0] && s_r.w_data[CTRL_SLEEP]) begin
               s_nxt.sleeping = 1'b1;
               s_nxt.read_seen = 1'b0;
            end
         end else if (!reg_hit(s_r.aw_addr, OFS_STATUS)) begin
            s_nxt.bresp = RESP_SLVERR;
         end
      end else if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // axi read
      if (s_axi_arvalid && s_axi_arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OKAY;
         if (reg_hit(s_axi_araddr, OFS_CTRL)) begin
            s_nxt.rdata = s_r.ctrl;
         end else if (reg_hit(s_axi_araddr, OFS_STATUS)) begin
            s_nxt.rdata = status;
         end else begin
            s_nxt.rdata = 32'h0000_0000;
            s_nxt.rresp = RESP_SLVERR;
         end
      end else if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      // shared rom data pin
      case (dmode)
         PM_ROM: begin
            s_nxt.sr_do = rom_eng_do;
            s_nxt.sr_oe = rom_eng_oe && s_r.strap_done;
         end
         PM_GPO: begin
            s_nxt.sr_do = s_r.ctrl[CTRL_GENERAL_OUTPUT_THREE];
            s_nxt.sr_oe = 1'b1;
         end
         PM_MON_A: begin
            s_nxt.sr_do = mii_tx_en;
            s_nxt.sr_oe = 1'b1;
         end
         default: begin
            s_nxt.sr_do = mii_tx_clk;
            s_nxt.sr_oe = 1'b1;
         end
      endcase
      // shared rom clock pin
      case (cmode)
         PM_ROM: s_nxt.sr_clk = rom_eng_clk;
         PM_GPO: s_nxt.sr_clk = s_r.ctrl[CTRL_GENERAL_OUTPUT_FOUR];
         PM_MON_A: s_nxt.sr_clk = mii_rx_dv;
         default: s_nxt.sr_clk = mii_rx_clk;
      endcase
      s_nxt.sr_cs = rom_eng_cs && (dmode == PM_ROM)
                    && (cmode == PM_ROM);
      // interrupt pin
      s_nxt.irq_o = s_r.ctrl[CTRL_IRQ_POL] ? irq_act : !irq_act;
      s_nxt.irq_oe = s_r.ctrl[CTRL_IRQ_OD] ? !s_nxt.irq_o : 1'b1;
      // pin reset clears all state except the csr store and re-arms strap capture
      if (!hw_reset_n) begin
         s_nxt = ST_RST;
         mem_we = 1'b0;
         mem_re = 1'b0;
         rx_fifo_pop = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // csr store
   hbpc_csr_mem #(
      .DW(32),
      .AW(CSR_DEPTH_AW)
   ) u_csr_mem (
      .ref_clk(ref_clk),
      .rst(rst),
      .we(mem_we),
      .waddr(mem_addr),
      .wdata(mem_wdata),
      .re(mem_re),
      .raddr(mem_addr),
      .rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign s_axi_awready = !s_r.aw_seen && !s_r.bvalid;
   assign s_axi_wready = !s_r.w_seen && !s_r.bvalid;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = !s_r.rvalid;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign host_data_o = s_r.rd_data;
   assign host_data_oe_lo = acc_rd;
   assign host_data_oe_hi = acc_rd && s_r.w32;
   assign data_hi_pulldown_en = !s_r.w32;
   assign irq_o = s_r.irq_o;
   assign irq_oe = s_r.irq_oe;
   assign bus_is_32 = s_r.w32;
   assign dflt_speed_100 = s_r.rate100;
   assign dflt_full_duplex = 1'b0;
   assign dflt_autoneg_en = s_r.rate100;
   assign tx_fifo_valid = s_r.tx_valid;
   assign tx_fifo_data = s_r.tx_data;
   assign serial_rom_data_o = s_r.sr_do;
   assign serial_rom_data_oe = s_r.sr_oe;
   assign serial_rom_clock = s_r.sr_clk;
   assign serial_rom_select = s_r.sr_cs;
   assign rom_eng_di = serial_rom_data_i;
   assign sleeping = s_r.sleeping;
   assign host_ready = s_r.read_seen;

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_oe_cs;
      @(posedge ref_clk) disable iff (rst)
      chip_select_n |-> !host_data_oe_lo && !host_data_oe_hi;
   endproperty
   a_oe_cs: assert property (p_oe_cs)
      else $error("data driven without chip select");

   property p_oe_rd;
      @(posedge ref_clk) disable iff (rst)
      host_data_oe_lo == (!chip_select_n && !read_strobe_n);
   endproperty
   a_oe_rd: assert property (p_oe_rd)
      else $error("data enable not tied to selected read");

   property p_pulldown;
      @(posedge ref_clk) disable iff (rst || !hw_reset_n)
      $rose(s_r.strap_done) |->
         data_hi_pulldown_en == !$past(serial_rom_data_i);
   endproperty
   a_pulldown: assert property (p_pulldown)
      else $error("upper pulldown wrong for bus width");

   property p_wake;
      @(posedge ref_clk) disable iff (rst || !hw_reset_n)
      (sleeping && wr_start) |=> !sleeping;
   endproperty
   a_wake: assert property (p_wake)
      else $error("write with chip select did not wake");

   property p_early_wr;
      @(posedge ref_clk) disable iff (rst)
      (wr_start && !host_ready) |=> !tx_fifo_valid;
   endproperty
   a_early_wr: assert property (p_early_wr)
      else $error("write took effect before first read");

   property p_fifo_wr;
      @(posedge ref_clk) disable iff (rst || !hw_reset_n)
      (wr_start && fifo_window_select && host_ready && !sleeping
       && bus_is_32) |=> tx_fifo_valid && tx_fifo_data == $past(host_data_i);
   endproperty
   a_fifo_wr: assert property (p_fifo_wr)
      else $error("fifo window write not sent to tx fifo");

   property p_half_lo;
      @(posedge ref_clk) disable iff (rst)
      (wr_start && !bus_is_32 && !host_addr[1]) |=> !tx_fifo_valid;
   endproperty
   a_half_lo: assert property (p_half_lo)
      else $error("low half write pushed a word");

   property p_rate_hold;
      @(posedge ref_clk) disable iff (rst || !hw_reset_n)
      ($past(s_r.strap_done) && s_r.strap_done) |->
         $stable(dflt_speed_100) ##1 $stable(dflt_speed_100);
   endproperty
   a_rate_hold: assert property (p_rate_hold)
      else $error("rate default changed after latch");

   property p_width_hold;
      @(posedge ref_clk) disable iff (rst || !hw_reset_n)
      $past(s_r.strap_done) && s_r.strap_done |-> $stable(bus_is_32);
   endproperty
   a_width_hold: assert property (p_width_hold)
      else $error("bus width changed after latch");

   property p_rom_cs;
      @(posedge ref_clk) disable iff (rst || !hw_reset_n)
      (dmode != PM_ROM || cmode != PM_ROM) |=> !serial_rom_select;
   endproperty
   a_rom_cs: assert property (p_rom_cs)
      else $error("rom select active while pin repurposed");

   property p_irq;
      @(posedge ref_clk) disable iff (rst || !hw_reset_n)
      !rst && hw_reset_n && !s_r.ctrl[CTRL_IRQ_OD] |=> irq_oe &&
         irq_o == ($past(irq_act) ~^ $past(s_r.ctrl[CTRL_IRQ_POL]));
   endproperty
   a_irq: assert property (p_irq)
      else $error("push-pull irq level wrong");
endmodule

/* File: hbpc_host_model.sv */
// Purpose: host processor model on the sram-like pins
// Assumes: called just after a rising ref_clk edge
// Notes: released data lines show a pattern that flips every cycle
`timescale 1ns/10ps
module hbpc_host_model (
   // clock
   input wire logic ref_clk,
   // data pins
   output logic [31:0] host_data_i,
   input wire logic [31:0] host_data_o,
   input wire logic host_data_oe_lo,
   // address and strobes
   output logic [7:1] host_addr,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic chip_select_n
);
   logic [31:0] wd = 32'h0;
   logic [31:0] last = 32'h0;
   logic drv = 1'b0;
   initial begin
      host_addr = 7'h0;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      chip_select_n = 1'b1;
   end
   always @(posedge ref_clk) last <= host_data_i;
   assign host_data_i = drv ? wd : host_data_oe_lo ? host_data_o : ~last;
   ////////////////////////////////////////////////////////////////////////
   // read cycle, address held through the strobe
   task automatic rd(input logic [7:1] a, input logic cs,
                     output logic [31:0] q);
      host_addr <= a;
      chip_select_n <= ~cs;
      read_strobe_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      q = host_data_o;
      read_strobe_n <= 1'b1;
      chip_select_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask
   // write cycle, data held with the strobe
   task automatic wr(input logic [7:1] a, input logic [31:0] v,
                     input logic cs);
      host_addr <= a;
      wd <= v;
      drv <= 1'b1;
      chip_select_n <= ~cs;
      write_strobe_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      write_strobe_n <= 1'b1;
      chip_select_n <= 1'b1;
      drv <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench for the host bus pin block
// Assumes: 50 MHz ref_clk, fixed xorshift seed
// Notes: registers over AXI4-Lite, host pins through the model
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
$display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top
   import hbpc_pkg::*;
;
   logic ref_clk, rst = 1'b1, hw_reset_n = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, host_data_i;
   logic [31:0] host_data_o, tx_fifo_data, rx_fifo_data = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [IRQ_SRC_N-1:0] irq_sources = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic host_data_oe_hi, host_data_oe_lo, data_hi_pulldown_en;
   logic [7:1] host_addr;
   logic read_strobe_n, write_strobe_n, chip_select_n;
   logic fifo_window_select = 1'b0, link_rate_strap = 1'b0;
   logic irq_o, irq_oe, bus_is_32, dflt_speed_100, dflt_full_duplex;
   logic dflt_autoneg_en, tx_fifo_valid, rx_fifo_pop, rom_eng_di;
   logic serial_rom_data_i = 1'b1, serial_rom_data_o, serial_rom_data_oe;
   logic serial_rom_clock, serial_rom_select, sleeping, host_ready;
   logic rom_eng_do = 1'b0, rom_eng_oe = 1'b0, rom_eng_clk = 1'b0;
   logic rom_eng_cs = 1'b1, mii_tx_en = 1'b0, mii_tx_clk = 1'b0;
   logic mii_rx_dv = 1'b0, mii_rx_clk = 1'b0, sb, a;
   logic [31:0] seed = 32'h5d5b, txd, d, r, q;
   int fails = 0;
   int compares = 0;
   int txn = 0;
   int pops = 0;
   int n;
   hbpc_top i_hbpc_top (.ref_clk, .rst, .hw_reset_n, .s_axi_awvalid,
      .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .host_data_i, .host_data_o, .host_data_oe_hi, .host_data_oe_lo,
      .data_hi_pulldown_en, .host_addr, .read_strobe_n, .write_strobe_n,
      .chip_select_n, .fifo_window_select, .irq_sources, .irq_o, .irq_oe,
      .link_rate_strap, .bus_is_32, .dflt_speed_100, .dflt_full_duplex,
      .dflt_autoneg_en, .tx_fifo_valid, .tx_fifo_data, .rx_fifo_pop,
      .rx_fifo_data, .serial_rom_data_i, .serial_rom_data_o,
      .serial_rom_data_oe, .serial_rom_clock, .serial_rom_select,
      .rom_eng_do, .rom_eng_oe, .rom_eng_clk, .rom_eng_cs, .rom_eng_di,
      .mii_tx_en, .mii_tx_clk, .mii_rx_dv, .mii_rx_clk, .sleeping,
      .host_ready);
   hbpc_host_model i_host (.ref_clk, .host_data_i, .host_data_o,
      .host_data_oe_lo, .host_addr, .read_strobe_n, .write_strobe_n,
      .chip_select_n);
   ////////////////////////////////////////////////////////////////////////
   // clock, tx capture, helpers
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (rx_fifo_pop) pops <= pops + 1;
   always @(posedge ref_clk) if (tx_fifo_valid) begin
      txn <= txn + 1;
      txd <= tx_fifo_data;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic pin_exp(input logic [1:0] m,
                                    input logic g, t, c, e);
      return m == 2'h0 ? e : m == 2'h1 ? g : m == 2'h2 ? t : c;
   endfunction
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] v,
                         output logic [1:0] resp);
      @(posedge ref_clk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] ad, output logic [31:0] v,
                         output logic [1:0] resp);
      @(posedge ref_clk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic print_verdict();
      if (fails == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      d = xs();
      sb = d[0];
      link_rate_strap <= sb;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      link_rate_strap <= ~sb;
      @(posedge ref_clk);
      `CHK("bus_is_32", 1'b1, bus_is_32)
      `CHK("speed", sb, dflt_speed_100)
      `CHK("autoneg", sb, dflt_autoneg_en)
      `CHK("duplex", 1'b0, dflt_full_duplex)
      `CHK("pulldown", 1'b0, data_hi_pulldown_en)
      fifo_window_select <= 1'b1;
      r = xs();
      i_host.wr(r[7:1], r, 1'b1);
      `CHK("early write", 0, txn)
      d = xs();
      rx_fifo_data <= d;
      i_host.rd(r[7:1], 1'b1, q);
      `CHK("fifo read", d, q)
      `CHK("oe idle", 1'b0, host_data_oe_lo)
      `CHK("ready", 1'b1, host_ready)
      d = xs();
      i_host.wr(r[7:1], d, 1'b0);
      `CHK("no select", 0, txn)
      i_host.wr(r[7:1], d, 1'b1);
      `CHK("tx count", 1, txn)
      `CHK("tx data", d, txd)
      fifo_window_select <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         r = xs();
         d = xs();
         r[7] = 1'b1;
         r[1] = 1'b0;
         i_host.wr(r[7:1], d, 1'b1);
         i_host.rd(r[7:1], 1'b1, q);
         `CHK("csr word", d, q)
      end
      `CHK("csr no tx", 1, txn)
      for (int m = 0; m < 16; m++) begin
         d = xs();
         {mii_tx_en, mii_tx_clk, mii_rx_dv, mii_rx_clk} <= d[5:2];
         {rom_eng_do, rom_eng_clk} <= d[1:0];
         axi_wr(OFS_CTRL, {22'h0, d[9:8], m[3:0], 4'h0}, rs);
         repeat (3) @(posedge ref_clk);
         q[0] = pin_exp(m[1:0], d[8], d[5], d[4], d[1]);
         q[1] = pin_exp(m[3:2], d[9], d[3], d[2], d[0]);
         `CHK("data pin", q[0], serial_rom_data_o)
         `CHK("clock pin", q[1], serial_rom_clock)
         `CHK("select", m[3:0] == 0, serial_rom_select)
         `CHK("data oe", m[1:0] != 0, serial_rom_data_oe)
         `CHK("rom di", 1'b1, rom_eng_di)
      end
      for (int i = 0; i < 8; i++) begin
         d = xs();
         irq_sources <= d[3:0];
         axi_wr(OFS_CTRL, {16'h0, d[7:4], 10'h0, i[1:0]}, rs);
         repeat (3) @(posedge ref_clk);
         a = |(d[3:0] & d[7:4]);
         `CHK("irq", i[0] ? a : ~a, irq_o)
         `CHK("irq oe", i[1] ? (i[0] ? ~a : a) : 1'b1, irq_oe)
      end
      axi_rd(OFS_STATUS, q, rs);
      `CHK("status", {24'h0, d[3:0], 2'b10, sb, 1'b1}, q)
      axi_rd(8'h40, q, rs);
      `CHK("unmapped", RESP_SLVERR, rs)
      axi_wr(OFS_CTRL, 32'h4, rs);
      repeat (2) @(posedge ref_clk);
      `CHK("sleep", 1'b1, sleeping)
      n = txn;
      i_host.wr(7'h40, d, 1'b1);
      `CHK("wake", 1'b0, sleeping)
      fifo_window_select <= 1'b1;
      i_host.wr(7'h0, d, 1'b1);
      `CHK("write after wake", n, txn)
      serial_rom_data_i <= 1'b0;
      hw_reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      hw_reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      axi_rd(OFS_CTRL, q, rs);
      `CHK("ctrl pin reset", CTRL_RST, q)
      `CHK("16-bit", 1'b0, bus_is_32)
      `CHK("pulldown on", 1'b1, data_hi_pulldown_en)
      d = xs();
      rx_fifo_data <= d;
      i_host.rd(7'h0, 1'b1, q);
      `CHK("low half", d[15:0], q[15:0])
      rx_fifo_data <= ~d;
      i_host.rd(7'h1, 1'b1, q);
      `CHK("high half", d[31:16], q[15:0])
      `CHK("rx pops", 2, pops)
      r = xs();
      n = txn;
      i_host.wr(7'h0, {16'h0, r[15:0]}, 1'b1);
      i_host.wr(7'h1, {16'h0, r[31:16]}, 1'b1);
      `CHK("tx pairs", n + 1, txn)
      `CHK("tx word", r, txd)
      print_verdict();
   end
endmodule
